// >>> hsc_pkg.sv
// Shared constants and types of the power-switch register bank
package hsc_pkg;
   // Register pointer values
   localparam logic [2:0] HSC_PTR_CTRL     = 3'h0;
   localparam logic [2:0] HSC_PTR_ALERT    = 3'h1;
   localparam logic [2:0] HSC_PTR_STATUS   = 3'h2;
   // Control register field positions
   localparam int         HSC_CTRL_GPIO_HI = 7;
   localparam int         HSC_CTRL_GPIO_LO = 6;
   localparam int         HSC_CTRL_ADC_OFF = 5;
   localparam int         HSC_CTRL_MASS_EN = 4;
   localparam int         HSC_CTRL_FET_ON  = 3;
   localparam int         HSC_CTRL_OC_RTRY = 2;
   localparam int         HSC_CTRL_UV_RTRY = 1;
   localparam int         HSC_CTRL_OV_RTRY = 0;
   // Alert register field positions
   localparam int         HSC_ALRT_GPO     = 6;
   localparam int         HSC_ALRT_EN_HI   = 5;
   // Reset values; control bit 2 comes from a module parameter
   localparam logic [7:0] HSC_CTRL_RST     = 8'h13;
   localparam logic [6:0] HSC_ALRT_RST     = 7'h00;
   // GPIO function codes
   localparam logic [1:0] HSC_GPIO_PGOOD   = 2'h0;
   localparam logic [1:0] HSC_GPIO_PBAD    = 2'h1;
   localparam logic [1:0] HSC_GPIO_OUT     = 2'h2;
   localparam logic [1:0] HSC_GPIO_IN      = 2'h3;
   // Tri-level address pin codes
   localparam logic [1:0] HSC_LVL_LOW      = 2'h0;
   localparam logic [1:0] HSC_LVL_HIGH     = 2'h2;
   // Seven-bit bus addresses, then eight-bit broadcast and response address bytes
   localparam logic [6:0] HSC_ADDR_LOW     = 7'h48;
   localparam logic [6:0] HSC_ADDR_OPEN    = 7'h4a;
   localparam logic [6:0] HSC_ADDR_HIGH    = 7'h4b;
   localparam logic [7:0] HSC_MASS_BYTE    = 8'hbe;
   localparam logic [7:0] HSC_ARA_BYTE     = 8'h19;
   localparam int         HSC_NFAULT       = 6;

   typedef enum logic [2:0] {
      HSC_PH_IDLE,
      HSC_PH_CMD,
      HSC_PH_DATA,
      HSC_PH_DONE,
      HSC_PH_READ,
      HSC_PH_ARA
   } hsc_phase_e;
endpackage

// >>> hsc_sync.sv
// Two-flop synchroniser for a group of pin levels
module hsc_sync
   import hsc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         ref_clk_in,
   input  wire logic         rst_b_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hsc_sync_s;

   hsc_sync_s st_r;
   hsc_sync_s st_nxt;

   // First stage feeds only the second stage
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '0;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   assign q_out = st_r.s2;
endmodule

// >>> hsc_alert.sv
// Alert request: edge of an enabled fault bit, held until released
module hsc_alert
   import hsc_pkg::*;
(
   input  wire logic                ref_clk_in,
   input  wire logic                rst_b_in,
   input  wire logic                ce_in,
   input  wire logic [HSC_NFAULT-1:0] fault_in,
   input  wire logic [HSC_NFAULT-1:0] enable_in,
   input  wire logic                release_in,
   output logic                     pending_out
);
   typedef struct packed {
      logic [HSC_NFAULT-1:0] prev;
      logic                  pend;
   } hsc_alert_s;

   hsc_alert_s st_r;
   hsc_alert_s st_nxt;
   logic       rise;

   // Only a fresh set raises it, so a standing fault stays quiet
   always_comb begin
      st_nxt      = st_r;
      rise        = |(fault_in & ~st_r.prev & enable_in);
      st_nxt.prev = fault_in;
      if (release_in) begin
         st_nxt.pend = 1'b0;
      end
      if (rise) begin
         st_nxt.pend = 1'b1; // Set beats release
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '0;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   assign pending_out = st_r.pend;
endmodule

// >>> hsc_regs.sv
// Control, alert-enable and status registers of the power switch
// What this block does
// (R1) Address from last select pin: 90/94/96
// (R2) Control 7:6 pick GPIO function
// (R3) Status bit 6 shows GPIO pin level
// (R4) Control bit 5 halts the converter
// (R5) Control bit 4 admits broadcast writes
// (R6) Control bit 3 commands transistor, debounce loads
// (R7) Control bit 2 overcurrent retry, default parameter
// (R8) Control bit 1 undervoltage retry, default 1
// (R9) Control bit 0 overvoltage retry, default 1
// (R10) Alert bits 5:0 enable alert per event
// (R11) Status bit 7 shows transistor state
// (R12) Status bit 5 flags possible shorted transistor
// (R13) Status bit 4 set while enable pin low
// (R14) Status bit 3 set while feedback low
// (R15) Status bit 2 overcurrent during cool-down
// (R16) Status bit 1 set while undervoltage low
// (R17) Status bit 0 set while overvoltage high
// (R18) Command low three bits set register pointer
// (R19) Enabled fresh fault pulls alert low
// (R20) Alert response read returns address, releases
// (R21) Status writes ignored, alert bit 7 zero
// (R22) Defaults applied on reset
module hsc_regs
   import hsc_pkg::*;
#(
   parameter logic OC_RETRY_DEFAULT = 1'b0
) (
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_b_in,
   input  wire logic                  ce_in,
   // Byte-level side of the serial protocol engine
   input  wire logic                  stop_in,
   input  wire logic                  addr_stb_in,
   input  wire logic [7:0]            addr_byte_in,
   output logic                       addr_ack_out,
   input  wire logic                  wr_stb_in,
   input  wire logic [7:0]            wr_byte_in,
   input  wire logic                  rd_stb_in,
   output logic      [7:0]            rd_data_out,
   // Registers beyond the status register live outside
   input  wire logic [7:0]            ext_rd_data_in,
   output logic      [2:0]            ext_ptr_out,
   output logic                       ext_wr_stb_out,
   output logic      [7:0]            ext_wr_data_out,
   // Fault register bits, same clock
   input  wire logic [HSC_NFAULT-1:0] fault_in,
   input  wire logic                  on_debounce_done_in,
   // Pins and analog comparators
   input  wire logic [1:0]            address_select_2_in,
   input  wire logic                  on_pin_in,
   input  wire logic                  en_b_pin_in,
   input  wire logic                  output_sense_pin_in,
   input  wire logic                  input_low_limit_pin_in,
   input  wire logic                  input_high_limit_pin_in,
   input  wire logic                  fet_short_cmp_in,
   input  wire logic                  oc_cooldown_in,
   input  wire logic                  fet_on_in,
   input  wire logic                  gpio_pin_in,
   output logic                       gpio_pin_out,
   output logic                       gpio_pin_oe_out,
   output logic                       alert_b_out,
   output logic                       alert_oe_out,
   // Control outputs
   output logic                       adc_halt_out,
   output logic                       fet_cmd_out,
   output logic                       oc_retry_out,
   output logic                       uv_retry_out,
   output logic                       ov_retry_out
);
   localparam int NPIN = 11;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [6:0] alrt;
      logic [2:0] ptr;
      hsc_phase_e phase;
      logic [7:0] rd_data;
      logic       ext_stb;
      logic [7:0] ext_data;
      logic       gpio_o;
      logic       gpio_oe;
   } hsc_regs_s;

   hsc_regs_s       st_r;
   hsc_regs_s       st_nxt;
   logic [NPIN-1:0] pins_raw;
   logic [NPIN-1:0] pins;
   logic [1:0]      adr_lvl;
   logic            on_lvl;
   logic            en_b_lvl;
   logic            fb_lvl;
   logic            uv_lvl;
   logic            ov_lvl;
   logic            short_lvl;
   logic            oc_lvl;
   logic            fet_lvl;
   logic            gpio_lvl;
   logic [6:0]      own_addr;
   logic [7:0]      status;
   logic            is_ara;
   logic            is_own;
   logic            is_mass;
   logic            pending;
   logic            release_alert;

   // All pin levels pass two flops before use
   assign pins_raw = {address_select_2_in, on_pin_in, en_b_pin_in,
                      output_sense_pin_in, input_low_limit_pin_in,
                      input_high_limit_pin_in, fet_short_cmp_in,
                      oc_cooldown_in, fet_on_in, gpio_pin_in};

   hsc_sync #(
      .W (NPIN)
   ) u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .ce_in      (ce_in),
      .d_in       (pins_raw),
      .q_out      (pins)
   );

   assign {adr_lvl, on_lvl, en_b_lvl, fb_lvl, uv_lvl, ov_lvl,
           short_lvl, oc_lvl, fet_lvl, gpio_lvl} = pins;

   // Small package: only the last select pin counts
   always_comb begin
      case (adr_lvl)
         HSC_LVL_LOW:  own_addr = HSC_ADDR_LOW;   // [R1]
         HSC_LVL_HIGH: own_addr = HSC_ADDR_HIGH;  // [R1]
         default:      own_addr = HSC_ADDR_OPEN;  // [R1]
      endcase
   end

   // Live status byte, read straight from the synchronised levels
   assign status = {fet_lvl,      // [R11]
                    gpio_lvl,     // [R3]
                    short_lvl,    // [R12]
                    ~en_b_lvl,    // [R13]
                    ~fb_lvl,      // [R14]
                    oc_lvl,       // [R15]
                    ~uv_lvl,      // [R16]
                    ov_lvl};      // [R17]

   // Address match; broadcast only for writes and only when admitted
   assign is_ara  = (addr_byte_in == HSC_ARA_BYTE) && pending;            // [R20]
   assign is_own  = (addr_byte_in[7:1] == own_addr);                      // [R1]
   assign is_mass = (addr_byte_in == HSC_MASS_BYTE)
                    && st_r.ctrl[HSC_CTRL_MASS_EN];                       // [R5]
   assign addr_ack_out = addr_stb_in && (is_ara || is_own || is_mass);

   // Alert drops on response read or when addressed directly
   assign release_alert = (rd_stb_in && (st_r.phase == HSC_PH_ARA))      // [R20]
                          || (addr_stb_in && is_own);

   hsc_alert u_alert (
      .ref_clk_in  (ref_clk_in),
      .rst_b_in    (rst_b_in),
      .ce_in       (ce_in),
      .fault_in    (fault_in),
      .enable_in   (st_r.alrt[HSC_ALRT_EN_HI:0]),                        // [R10]
      .release_in  (release_alert),
      .pending_out (pending)
   );

   // Transaction walker, register writes and the read mux
   always_comb begin
      st_nxt         = st_r;
      st_nxt.ext_stb = 1'b0;
      if (addr_stb_in) begin
         if (is_ara) begin
            st_nxt.phase = HSC_PH_ARA;                                    // [R20]
         end else if (is_own && addr_byte_in[0]) begin
            st_nxt.phase = HSC_PH_READ;
         end else if (is_own || (is_mass && !addr_byte_in[0])) begin
            st_nxt.phase = HSC_PH_CMD;                                    // [R5]
         end else begin
            st_nxt.phase = HSC_PH_IDLE;
         end
      end else if (wr_stb_in) begin
         case (st_r.phase)
            HSC_PH_CMD: begin
               st_nxt.ptr   = wr_byte_in[2:0];                            // [R18]
               st_nxt.phase = HSC_PH_DATA;
            end
            HSC_PH_DATA: begin
               st_nxt.phase = HSC_PH_DONE;  // Second data byte is ignored
               case (st_r.ptr)
                  HSC_PTR_CTRL:   st_nxt.ctrl = wr_byte_in;               // [R2]
                  HSC_PTR_ALERT:  st_nxt.alrt = wr_byte_in[6:0];          // [R21]
                  HSC_PTR_STATUS: st_nxt.ctrl = st_r.ctrl;                // [R21]
                  default: begin
                     st_nxt.ext_stb  = 1'b1;
                     st_nxt.ext_data = wr_byte_in;
                  end
               endcase
            end
            default: st_nxt.phase = st_r.phase;
         endcase
      end
      if (stop_in) begin
         st_nxt.phase = HSC_PH_IDLE;
      end
      // Debounce end beats a host write in the same cycle
      if (on_debounce_done_in) begin
         st_nxt.ctrl[HSC_CTRL_FET_ON] = on_lvl;                           // [R6]
      end
      // Read data is registered; a response read returns our own address
      if (st_r.phase == HSC_PH_ARA) begin
         st_nxt.rd_data = {own_addr, 1'b0};                               // [R20]
      end else begin
         case (st_r.ptr)
            HSC_PTR_CTRL:   st_nxt.rd_data = st_r.ctrl;
            HSC_PTR_ALERT:  st_nxt.rd_data = {1'b0, st_r.alrt};           // [R21]
            HSC_PTR_STATUS: st_nxt.rd_data = status;
            default:        st_nxt.rd_data = ext_rd_data_in;
         endcase
      end
      // GPIO function select; input mode releases the pin
      st_nxt.gpio_oe = 1'b1;
      case (st_r.ctrl[HSC_CTRL_GPIO_HI:HSC_CTRL_GPIO_LO])
         HSC_GPIO_PGOOD: st_nxt.gpio_o = fb_lvl;                          // [R2]
         HSC_GPIO_PBAD:  st_nxt.gpio_o = ~fb_lvl;                         // [R2]
         HSC_GPIO_OUT:   st_nxt.gpio_o = st_r.alrt[HSC_ALRT_GPO];         // [R2]
         HSC_GPIO_IN: begin
            st_nxt.gpio_o  = 1'b0;
            st_nxt.gpio_oe = 1'b0;                                        // [R2]
         end
         default:        st_nxt.gpio_o = 1'b0;
      endcase
   end

   // Single state register; defaults land on reset
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r          <= '0;
         st_r.ctrl     <= {HSC_CTRL_RST[7:3], OC_RETRY_DEFAULT,
                           HSC_CTRL_RST[1:0]};                            // [R22]
         st_r.alrt     <= HSC_ALRT_RST;                                   // [R22]
         st_r.phase    <= HSC_PH_IDLE;
         st_r.gpio_oe  <= 1'b1;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops; alert data is a constant low
   assign rd_data_out     = st_r.rd_data;
   assign ext_ptr_out     = st_r.ptr;
   assign ext_wr_stb_out  = st_r.ext_stb;
   assign ext_wr_data_out = st_r.ext_data;
   assign gpio_pin_out    = st_r.gpio_o;
   assign gpio_pin_oe_out = st_r.gpio_oe;
   assign alert_b_out     = 1'b0;       // Open drain: only ever pulls low
   assign alert_oe_out    = pending;    // [R19]
   assign adc_halt_out    = st_r.ctrl[HSC_CTRL_ADC_OFF];                  // [R4]
   assign fet_cmd_out     = st_r.ctrl[HSC_CTRL_FET_ON];                   // [R6]
   assign oc_retry_out    = st_r.ctrl[HSC_CTRL_OC_RTRY];                  // [R7]
   assign uv_retry_out    = st_r.ctrl[HSC_CTRL_UV_RTRY];                  // [R8]
   assign ov_retry_out    = st_r.ctrl[HSC_CTRL_OV_RTRY];                  // [R9]

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_cmd_byte;
      ce_in && wr_stb_in && !addr_stb_in && !stop_in
      && st_r.phase == HSC_PH_CMD;
   endsequence

   sequence s_data_byte;
      ce_in && wr_stb_in && !addr_stb_in && !stop_in
      && st_r.phase == HSC_PH_DATA;
   endsequence

   a_ptr_latch: assert property (s_cmd_byte  // [R18]
      |=> st_r.ptr == $past(wr_byte_in[2:0]))
      else $error("pointer not taken from command byte");

   a_ctrl_write: assert property (s_data_byte ##0 st_r.ptr == HSC_PTR_CTRL  // [R2]
      && !on_debounce_done_in |=> st_r.ctrl == $past(wr_byte_in))
      else $error("control write lost");

   a_status_ro: assert property (s_data_byte ##0 st_r.ptr == HSC_PTR_STATUS  // [R21]
      && !on_debounce_done_in |=> $stable(st_r.ctrl) && $stable(st_r.alrt))
      else $error("status write changed a register");

   a_alrt_b7_zero: assert property (ce_in && st_r.ptr == HSC_PTR_ALERT  // [R21]
      && st_r.phase != HSC_PH_ARA |=> !rd_data_out[7])
      else $error("alert bit 7 read as one");

   a_mass_gate: assert property (addr_stb_in && addr_byte_in == HSC_MASS_BYTE  // [R5]
      && !st_r.ctrl[HSC_CTRL_MASS_EN] && !pending |-> !addr_ack_out)
      else $error("broadcast acknowledged while disabled");

   a_fet_load: assert property (ce_in && on_debounce_done_in  // [R6]
      |=> fet_cmd_out == $past(on_lvl))
      else $error("transistor bit not loaded at debounce end");

   a_own_addr: assert property (ce_in && adr_lvl == HSC_LVL_HIGH  // [R1]
      && addr_stb_in && addr_byte_in == 8'h96 |-> addr_ack_out)
      else $error("own address not acknowledged");

   a_ara_reply: assert property (ce_in && st_r.phase == HSC_PH_ARA  // [R20]
      && !stop_in && !addr_stb_in |=> rd_data_out == {own_addr, 1'b0})
      else $error("response read did not return own address");

   a_gpio_input: assert property (ce_in  // [R2]
      && st_r.ctrl[HSC_CTRL_GPIO_HI:HSC_CTRL_GPIO_LO] == HSC_GPIO_IN
      |=> !gpio_pin_oe_out)
      else $error("GPIO driven in input mode");

   a_alert_edge: assert property (ce_in && !release_alert  // [R19]
      && |(fault_in & ~u_alert.st_r.prev & st_r.alrt[5:0])
      |=> alert_oe_out)
      else $error("enabled fault did not raise alert");

   // Control outputs other than the transistor command follow a written control byte
   a_ctrl_outs: assert property (s_data_byte ##0 st_r.ptr == HSC_PTR_CTRL  // [R4] [R7] [R8] [R9]
      |=> {adc_halt_out, oc_retry_out, uv_retry_out, ov_retry_out}
      == {$past(wr_byte_in[5]), $past(wr_byte_in[2:0])})
      else $error("control outputs not loaded");

   a_gpio_out: assert property (ce_in  // [R2]
      && st_r.ctrl[HSC_CTRL_GPIO_HI:HSC_CTRL_GPIO_LO] == HSC_GPIO_OUT
      |=> gpio_pin_oe_out && gpio_pin_out == $past(st_r.alrt[HSC_ALRT_GPO]))
      else $error("GPIO output bit not driven");

   a_gpio_pgood: assert property (ce_in  // [R2]
      && st_r.ctrl[HSC_CTRL_GPIO_HI:HSC_CTRL_GPIO_LO] == HSC_GPIO_PGOOD
      |=> gpio_pin_oe_out && gpio_pin_out == $past(fb_lvl))
      else $error("GPIO power-good level wrong");

   a_status_read: assert property (ce_in && st_r.ptr == HSC_PTR_STATUS  // [R13] [R16]
      && st_r.phase != HSC_PH_ARA
      |=> rd_data_out[4] != $past(en_b_lvl) && rd_data_out[1] != $past(uv_lvl))
      else $error("enable or undervoltage flag inverted");

   a_alert_quiet: assert property (ce_in && !alert_oe_out  // [R19]
      && !(|(fault_in & ~u_alert.st_r.prev & st_r.alrt[5:0])) |=> !alert_oe_out)
      else $error("alert raised without a fresh fault");

   a_alert_release: assert property (ce_in && rd_stb_in && st_r.phase == HSC_PH_ARA  // [R20]
      && !(|(fault_in & ~u_alert.st_r.prev & st_r.alrt[5:0])) |=> !alert_oe_out)
      else $error("alert held after response read");

   a_ext_write: assert property (s_data_byte ##0 st_r.ptr > HSC_PTR_STATUS  // [R18]
      |=> ext_wr_stb_out && ext_wr_data_out == $past(wr_byte_in))
      else $error("outer register write lost");
endmodule

// >>> hsc_regs_note_end.sv
// Holds no logic of its own

// >>> hsc_host.sv
// Host byte-engine model that drives the register bank from the bus side
module hsc_host
   import hsc_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       ack_in,
   input  wire logic [7:0] rd_data_in,
   output logic            stop_out,
   output logic            addr_stb_out,
   output logic [7:0]      addr_byte_out,
   output logic            wr_stb_out,
   output logic [7:0]      wr_byte_out,
   output logic            rd_stb_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bytes carry a pattern, never a stale value
   initial begin
      {stop_out, addr_stb_out, wr_stb_out, rd_stb_out} = 4'h0;
      addr_byte_out = 8'h5a;
      wr_byte_out   = 8'ha5;
   end
   // Address byte; ack is combinational, so it is looked at mid-cycle
   task automatic addr(input logic [7:0] b, output logic a);
      @(negedge clk_in);
      addr_byte_out = b;
      addr_stb_out  = 1'b1;
      #2 a = ack_in;
      @(negedge clk_in);
      addr_stb_out  = 1'b0;
      addr_byte_out = ~b;
   endtask
   // One written byte, held across one rising edge
   task automatic put(input logic [7:0] b);
      @(negedge clk_in);
      wr_byte_out = b;
      wr_stb_out  = 1'b1;
      @(negedge clk_in);
      wr_stb_out  = 1'b0;
      wr_byte_out = ~b;
   endtask
   // One-cycle pulse: read-byte shifted out, or stop
   task automatic pulse(input logic rd);
      @(negedge clk_in);
      {rd_stb_out, stop_out} = {rd, !rd};
      @(negedge clk_in);
      {rd_stb_out, stop_out} = 2'h0;
   endtask
   // Write byte: address, command, data, stop
   task automatic wr(input logic [7:0] dev, cmd, dat, output logic a);
      addr(dev, a);
      put(cmd);
      put(dat);
      pulse(1'b0);
   endtask
   // Read byte: address, command, repeated start with read bit, one byte
   task automatic rd(input logic [7:0] dev, cmd, output logic [7:0] d);
      logic a;
      addr(dev, a);
      put(cmd);
      addr(dev | 8'h01, a);
      d = rd_data_in;
      pulse(1'b1);
      pulse(1'b0);
   endtask
   // Alert response read: the answer byte is the device address
   task automatic ara(output logic a, output logic [7:0] d);
      addr(8'h19, a);
      // Reply byte is registered one edge after the phase change
      @(negedge clk_in);
      d = rd_data_in;
      pulse(1'b1);
      pulse(1'b0);
   endtask
endmodule

// >>> tb_hsc_regs.sv
// Self-checking bench of the power-switch register bank
module tb_hsc_regs
   import hsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] DEV = 8'h96;
   logic       ref_clk, rst_b, ce, stp, a_stb, w_stb, r_stb, ack, ext_ws;
   logic       gpo, gpo_oe, al_b, al_oe, halt, fet_cmd, oc_r, uv_r, ov_r, deb;
   logic       on_pin, en_b, fb, uv, ov, fshort, occ, fet_on, gpio_ext, a;
   logic [7:0] a_byte, w_byte, rd_data, ext_rd, ext_wd, ws_data, d;
   logic [5:0] fault;
   logic [2:0] ext_ptr;
   logic [1:0] adr;
   integer     n_errors, tests_run, ws_cnt = 0;
   // Pin level seen by the bank: its own drive, else the board
   wire logic  gpio_pin = gpo_oe ? gpo : gpio_ext;

   hsc_regs #(.OC_RETRY_DEFAULT(1'b0)) hsc_regs_i (
      .ref_clk_in(ref_clk), .rst_b_in(rst_b), .ce_in(ce), .stop_in(stp),
      .addr_stb_in(a_stb), .addr_byte_in(a_byte), .addr_ack_out(ack),
      .wr_stb_in(w_stb), .wr_byte_in(w_byte), .rd_stb_in(r_stb),
      .rd_data_out(rd_data), .ext_rd_data_in(ext_rd), .ext_ptr_out(ext_ptr),
      .ext_wr_stb_out(ext_ws), .ext_wr_data_out(ext_wd), .fault_in(fault),
      .on_debounce_done_in(deb), .address_select_2_in(adr), .on_pin_in(on_pin),
      .en_b_pin_in(en_b), .output_sense_pin_in(fb), .input_low_limit_pin_in(uv),
      .input_high_limit_pin_in(ov), .fet_short_cmp_in(fshort),
      .oc_cooldown_in(occ), .fet_on_in(fet_on), .gpio_pin_in(gpio_pin),
      .gpio_pin_out(gpo), .gpio_pin_oe_out(gpo_oe), .alert_b_out(al_b),
      .alert_oe_out(al_oe), .adc_halt_out(halt), .fet_cmd_out(fet_cmd),
      .oc_retry_out(oc_r), .uv_retry_out(uv_r), .ov_retry_out(ov_r));
   hsc_host hsc_host_i (
      .clk_in(ref_clk), .ack_in(ack), .rd_data_in(rd_data), .stop_out(stp),
      .addr_stb_out(a_stb), .addr_byte_out(a_byte), .wr_stb_out(w_stb),
      .wr_byte_out(w_byte), .rd_stb_out(r_stb));

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Outer-register write strobes are counted, not just seen
   always @(posedge ref_clk) begin
      if (ext_ws === 1'b1) begin
         ws_cnt  <= ws_cnt + 1;
         ws_data <= ext_wd;
      end
   end

   task automatic chk8(input logic [7:0] g, e, input string m);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic chk1(input logic g, e, input string m);
      chk8({7'h00, g}, {7'h00, e}, m);
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Pins pass two sync flops, so give them a few cycles
   task automatic settle();
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic t_reset();
      hsc_host_i.rd(DEV, 8'h00, d);
      chk8(d, 8'h13, "control reset");
      hsc_host_i.rd(DEV, 8'h01, d);
      chk8(d, 8'h00, "alert reset");
      chk8({halt, fet_cmd, oc_r, uv_r, ov_r}, 5'h03, "control outs reset");
   endtask
   task automatic t_addr();
      logic [7:0] own [3] = '{8'h90, 8'h94, 8'h96};
      for (int i = 0; i < 3; i++) begin
         adr = 2'(i); // 0 low, 1 open, 2 high
         settle();
         for (int j = 0; j < 3; j++) begin
            hsc_host_i.addr(own[j], a);
            hsc_host_i.pulse(1'b0);
            chk1(a, i == j, "address ack");
         end
      end
   endtask
   task automatic t_ctrl();
      logic [7:0] v [2] = '{8'h2f, 8'h10};
      for (int i = 0; i < 2; i++) begin
         hsc_host_i.wr(DEV, 8'h00, v[i], a);
         hsc_host_i.rd(DEV, 8'h00, d);
         chk8(d, v[i], "control readback");
         chk8({3'h0, halt, fet_cmd, oc_r, uv_r, ov_r},
              {3'h0, v[i][5], v[i][3:0]}, "control outs");
      end
   endtask
   task automatic t_deb();
      for (int i = 1; i >= 0; i--) begin
         on_pin = i[0];
         settle();
         deb = 1'b1;
         @(negedge ref_clk);
         deb = 1'b0;
         settle();
         chk1(fet_cmd, i[0], "debounce load");
      end
   endtask
   task automatic t_mass();
      hsc_host_i.wr(8'hbe, 8'h00, 8'h00, a);
      chk1(a, 1'b1, "broadcast taken");
      hsc_host_i.wr(8'hbe, 8'h00, 8'h10, a);
      chk1(a, 1'b0, "broadcast refused");
      hsc_host_i.rd(DEV, 8'h00, d);
      chk8(d, 8'h00, "broadcast ignored");
   endtask
   task automatic t_gpio();
      hsc_host_i.wr(DEV, 8'h01, 8'h40, a);
      for (int m = 0; m < 4; m++) begin
         hsc_host_i.wr(DEV, 8'h00, {m[1:0], 6'h10}, a);
         settle();
         chk1(gpo_oe, m != 3, "gpio drive");
         hsc_host_i.rd(DEV, 8'h02, d);
         chk1(d[6], m[0] == 0, "gpio level");
      end
      gpio_ext = 1'b1;
      settle();
      hsc_host_i.rd(DEV, 8'h02, d);
      chk1(d[6], 1'b1, "gpio input high");
   endtask
   task automatic t_status();
      logic [7:0] p [2] = '{8'ha5, 8'h5a};
      for (int i = 0; i < 2; i++) begin
         {fet_on, gpio_ext, fshort, en_b, fb, occ, uv, ov} = p[i] ^ 8'h1a;
         settle();
         hsc_host_i.wr(DEV, 8'h02, ~p[i], a);
         hsc_host_i.rd(DEV, 8'h02, d);
         chk8(d, p[i], "status flags");
      end
      hsc_host_i.wr(DEV, 8'h01, 8'hc0, a);
      hsc_host_i.rd(DEV, 8'h01, d);
      chk8(d, 8'h40, "alert bit7");
   endtask
   task automatic t_ptr();
      integer c0;
      hsc_host_i.wr(DEV, 8'hf9, 8'h15, a);
      hsc_host_i.rd(DEV, 8'h01, d);
      chk8(d, 8'h15, "pointer low bits");
      hsc_host_i.rd(DEV, 8'h0b, d);
      chk8(d, 8'h3c, "outer read");
      c0 = ws_cnt;
      hsc_host_i.wr(DEV, 8'hfd, 8'h6e, a);
      chk8({5'(ws_cnt - c0), ext_ptr}, 8'h0d, "outer write");
      chk8(ws_data, 8'h6e, "outer data");
   endtask
   task automatic t_alert();
      for (int i = 0; i < 6; i++) begin
         hsc_host_i.wr(DEV, 8'h01, 8'h01 << i, a);
         fault = 6'h3f ^ (6'h01 << i);
         settle();
         chk1(al_oe, 1'b0, "masked faults");
         fault = 6'h3f;
         settle();
         chk8({al_b, al_oe}, 2'h1, "alert raised");
         hsc_host_i.ara(a, d);
         chk8(d, DEV, "response address");
         settle();
         chk1(al_oe, 1'b0, "released, no repeat");
         fault = 6'h00;
      end
      settle();
      fault = 6'h20;
      settle();
      chk1(al_oe, 1'b1, "alert re-armed");
      hsc_host_i.addr(DEV, a);
      hsc_host_i.pulse(1'b0);
      chk1(al_oe, 1'b0, "released by address");
      hsc_host_i.ara(a, d);
      chk1(a, 1'b0, "no response when idle");
   endtask

   // Main sequence; inputs change only at falling edges
   initial begin
      {rst_b, deb, on_pin, en_b, uv, ov, fshort, occ, fet_on, gpio_ext} = '0;
      {fb, ce} = 2'h3;
      {n_errors, tests_run} = '0;
      fault  = 6'h00;
      ext_rd = 8'h3c;
      adr    = HSC_LVL_HIGH;
      repeat (12) @(negedge ref_clk);
      rst_b = 1'b1;
      settle();
      t_reset();
      t_addr();
      t_ctrl();
      t_deb();
      t_mass();
      t_gpio();
      t_status();
      t_ptr();
      t_alert();
      stop_test();
   end
   // Watchdog: the run needs only a few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end
endmodule
